// [rtl/line_interface_control_regs.sv]
// line-feed supervision register bank with its threshold comparators
// assumes software on the same clock; measurements come from logic on i_clk
`timescale 1ns/1ps
`include "line_ctrl_consts.svh"

module line_interface_control_regs #(
  parameter bit HAS_CONVERTER = 1'b1
) (
  // clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_reset,
  // register port
  input  wire logic [7:0]                i_addr,
  input  wire logic [15:0]               i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [15:0]               o_rdata,
  // line state from the analog front end and direct registers
  input  wire line_ctrl_pkg::line_meas_t i_meas,
  input  wire logic                      i_hyst_enable,
  input  wire logic                      i_ringing_active,
  input  wire logic                      i_overhead_range_select,
  // configuration and supervision results
  output line_ctrl_pkg::line_cfg_t       o_cfg,
  output line_ctrl_pkg::line_status_t    o_status
);
  import line_ctrl_pkg::*;

  line_state_t state_r;
  line_state_t state_nxt;
  line_cfg_t   cfg;
  logic        in_bank;
  logic [3:0]  word_idx;
  logic [7:0]  addr_off;
  logic [2:0]  pwr_over;
  logic        upper_hit;
  logic        lower_miss;

  // window decode and word index
  assign addr_off = i_addr - `LC_ADDR_FIRST;
  assign word_idx = addr_off[3:0];
  assign in_bank  = (i_addr >= `LC_ADDR_FIRST) && (i_addr <= `LC_ADDR_LAST);

  // field extraction from the stored words
  always_comb begin
    cfg = '0;
    cfg.loop_close_upper_level    = state_r.bank[4'd0][`LC_THRESH6_MSB:`LC_FIELD_LSB];
    cfg.ring_trip_level           = state_r.bank[4'd1][`LC_THRESH6_MSB:`LC_FIELD_LSB];
    cfg.cm_negative_speedup_level = state_r.bank[4'd2][`LC_THRESH6_MSB:`LC_FIELD_LSB];
    cfg.cm_positive_speedup_level = state_r.bank[4'd3][`LC_THRESH6_MSB:`LC_FIELD_LSB];
    cfg.power_alarm_level_a       = state_r.bank[4'd4][`LC_POWER8_MSB:`LC_FIELD_LSB];
    cfg.power_alarm_level_b       = state_r.bank[4'd5][`LC_POWER8_MSB:`LC_FIELD_LSB];
    cfg.power_alarm_level_c       = state_r.bank[4'd6][`LC_POWER8_MSB:`LC_FIELD_LSB];
    cfg.loop_close_filter_value   = state_r.bank[4'd7][`LC_COEF13_MSB:`LC_FIELD_LSB];
    cfg.ring_trip_filter_value    = state_r.bank[4'd8][`LC_COEF13_MSB:`LC_FIELD_LSB];
    cfg.thermal_pole_a            = state_r.bank[4'd9][`LC_COEF13_MSB:`LC_FIELD_LSB];
    cfg.thermal_pole_b            = state_r.bank[4'd10][`LC_COEF13_MSB:`LC_FIELD_LSB];
    cfg.thermal_pole_c            = state_r.bank[4'd11][`LC_COEF13_MSB:`LC_FIELD_LSB];
    cfg.ringing_cm_bias           = state_r.bank[4'd12][`LC_CODE4_MSB:`LC_FIELD_LSB];
    // converter-less variant has no overhead control
    if (HAS_CONVERTER) begin
      cfg.overhead_voltage_code   = state_r.bank[4'd13][`LC_CODE4_MSB:`LC_FIELD_LSB];
    end
    cfg.loop_close_lower_level    = state_r.bank[4'd15][`LC_THRESH6_MSB:`LC_FIELD_LSB];
  end

  assign o_cfg = cfg;

  // per-pair power alarm compare, thresholds sign-extended
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pwr
      logic signed [15:0] est;
      logic signed [15:0] lvl;
      assign est = (g == 0) ? i_meas.power_est_a : ((g == 1) ? i_meas.power_est_b : i_meas.power_est_c);
      assign lvl = {{8{state_r.bank[4 + g][7]}}, state_r.bank[4 + g][7:0]};
      assign pwr_over[g] = est > lvl;
    end
  endgenerate

  // loop current against both window edges, codes of 1.27 mA
  assign upper_hit  = i_meas.loop_current >
                      $signed({{10{cfg.loop_close_upper_level[5]}}, cfg.loop_close_upper_level});
  assign lower_miss = i_meas.loop_current <
                      $signed({{10{cfg.loop_close_lower_level[5]}}, cfg.loop_close_lower_level});

  // next state: register writes, read data, supervision flags
  always_comb begin
    state_nxt = state_r;
    // read data stands for one cycle only
    state_nxt.rdata = `LC_READ_ZERO;
    if (i_wr && in_bank && (i_addr != `LC_ADDR_RESERVED)) begin
      state_nxt.bank[word_idx] = i_wdata;
    end
    if (i_rd && in_bank && (i_addr != `LC_ADDR_RESERVED)) begin
      state_nxt.rdata = state_r.bank[word_idx];
    end else if (i_rd) begin
      state_nxt.rdata = `LC_READ_ZERO;
    end
    // loop closure, with hysteresis window when enabled
    if (i_hyst_enable) begin
      if (upper_hit) begin
        state_nxt.status.loop_closed = 1'b1;
      end else if (lower_miss) begin
        state_nxt.status.loop_closed = 1'b0;
      end
    end else begin
      state_nxt.status.loop_closed = upper_hit;
    end
    // ring trip only meaningful while ringing
    state_nxt.status.ring_tripped = i_ringing_active &&
      (i_meas.ring_trip_sense > $signed({{10{cfg.ring_trip_level[5]}}, cfg.ring_trip_level}));
    // wider dc loop bandwidth on either common-mode excursion, 0.375 V codes
    state_nxt.status.dc_speedup =
      (i_meas.cm_voltage_neg > $signed({{10{cfg.cm_negative_speedup_level[5]}},
                                        cfg.cm_negative_speedup_level})) ||
      (i_meas.cm_voltage_pos > $signed({{10{cfg.cm_positive_speedup_level[5]}},
                                        cfg.cm_positive_speedup_level}));
    state_nxt.status.power_alarm = pwr_over;
    // reset clears flags and read data but leaves the bank as it was
    if (i_reset) begin
      state_nxt.rdata  = `LC_READ_ZERO;
      state_nxt.status = '0;
    end
  end

  // single state register
  always_ff @(posedge i_clk) begin
    state_r <= state_nxt;
  end

  assign o_rdata  = state_r.rdata;
  assign o_status = state_r.status;

endmodule // line_interface_control_regs

// [rtl/line_ctrl_consts.svh]
// offsets, field positions and widths of the line-feed supervision register bank
// assumes an 8-bit indirect address and 16-bit register words
`ifndef LINE_CTRL_CONSTS_SVH
`define LINE_CTRL_CONSTS_SVH

// register addresses
`define LC_ADDR_FIRST        8'h1c
`define LC_ADDR_LAST         8'h2b
`define LC_ADDR_LOOP_UPPER   8'h1c
`define LC_ADDR_RING_TRIP    8'h1d
`define LC_ADDR_CM_NEG       8'h1e
`define LC_ADDR_CM_POS       8'h1f
`define LC_ADDR_PWR_A        8'h20
`define LC_ADDR_PWR_B        8'h21
`define LC_ADDR_PWR_C        8'h22
`define LC_ADDR_LOOP_FILT    8'h23
`define LC_ADDR_RING_FILT    8'h24
`define LC_ADDR_THERM_A      8'h25
`define LC_ADDR_THERM_B      8'h26
`define LC_ADDR_THERM_C      8'h27
`define LC_ADDR_CM_BIAS      8'h28
`define LC_ADDR_OVERHEAD     8'h29
`define LC_ADDR_RESERVED     8'h2a
`define LC_ADDR_LOOP_LOWER   8'h2b

// number of words in the bank
`define LC_BANK_WORDS        16

// field positions, all fields sit at bit 0
`define LC_FIELD_LSB         0
`define LC_THRESH6_MSB       5
`define LC_POWER8_MSB        7
`define LC_COEF13_MSB        12
`define LC_CODE4_MSB         3

// word returned for reserved and unmapped addresses
`define LC_READ_ZERO         16'h0000

`endif

// [rtl/line_ctrl_pkg.sv]
// types shared by the line-feed supervision register bank
// assumes the constants header is compiled alongside
package line_ctrl_pkg;

  // measured line quantities, two's complement, same clock as the bank
  typedef struct packed {
    logic signed [15:0] loop_current;
    logic signed [15:0] ring_trip_sense;
    logic signed [15:0] cm_voltage_neg;
    logic signed [15:0] cm_voltage_pos;
    logic signed [15:0] power_est_a;
    logic signed [15:0] power_est_b;
    logic signed [15:0] power_est_c;
  } line_meas_t;

  // decoded configuration fields handed to the datapaths
  typedef struct packed {
    logic [5:0]  loop_close_upper_level;
    logic [5:0]  loop_close_lower_level;
    logic [5:0]  ring_trip_level;
    logic [5:0]  cm_negative_speedup_level;
    logic [5:0]  cm_positive_speedup_level;
    logic [7:0]  power_alarm_level_a;
    logic [7:0]  power_alarm_level_b;
    logic [7:0]  power_alarm_level_c;
    logic [12:0] loop_close_filter_value;
    logic [12:0] ring_trip_filter_value;
    logic [12:0] thermal_pole_a;
    logic [12:0] thermal_pole_b;
    logic [12:0] thermal_pole_c;
    logic [3:0]  ringing_cm_bias;
    logic [3:0]  overhead_voltage_code;
  } line_cfg_t;

  // supervision results
  typedef struct packed {
    logic       loop_closed;
    logic       ring_tripped;
    logic       dc_speedup;
    logic [2:0] power_alarm;
  } line_status_t;

  // whole state of the bank module
  typedef struct packed {
    logic [15:0][15:0] bank;
    logic [15:0]       rdata;
    line_status_t      status;
  } line_state_t;

endpackage

// [dv/line_regs_chk.sv]
// checker for the supervision register bank
// assumes it is bound to the bank's top module
`timescale 1ns/1ps
module line_regs_chk (
  // clock and reset
  input wire logic                         i_clk,
  input wire logic                         i_reset,
  // register port and line state
  input wire logic [7:0]                   i_addr,
  input wire logic [15:0]                  i_wdata,
  input wire logic                         i_wr,
  input wire logic                         i_rd,
  input wire logic [15:0]                  o_rdata,
  input wire line_ctrl_pkg::line_meas_t    i_meas,
  input wire logic                         i_ringing_active,
  input wire line_ctrl_pkg::line_cfg_t     o_cfg,
  input wire line_ctrl_pkg::line_status_t  o_status
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // sign-extended positive speed-up level
  wire logic signed [15:0] pos_lvl = {{10{o_cfg.cm_positive_speedup_level[5]}}, o_cfg.cm_positive_speedup_level};
  sequence s_wr(logic [7:0] a); i_wr && i_addr == a; endsequence
  sequence s_rd_dead; i_rd && (i_addr == 8'h2a || i_addr < 8'h1c || i_addr > 8'h2b); endsequence
  property p_upper; s_wr(8'h1c) |=> o_cfg.loop_close_upper_level == $past(i_wdata[5:0]); endproperty
  a_upper: assert property (p_upper) else $error("upper level not loaded");
  property p_lower; s_wr(8'h2b) |=> o_cfg.loop_close_lower_level == $past(i_wdata[5:0]); endproperty
  a_lower: assert property (p_lower) else $error("lower level not loaded");
  property p_filt; s_wr(8'h23) |=> o_cfg.loop_close_filter_value == $past(i_wdata[12:0]); endproperty
  a_filt: assert property (p_filt) else $error("loop filter not loaded");
  property p_pole; s_wr(8'h27) |=> o_cfg.thermal_pole_c == $past(i_wdata[12:0]); endproperty
  a_pole: assert property (p_pole) else $error("thermal pole not loaded");
  property p_pwr; s_wr(8'h20) |=> o_cfg.power_alarm_level_a == $past(i_wdata[7:0]); endproperty
  a_pwr: assert property (p_pwr) else $error("power level not loaded");
  property p_ovh; s_wr(8'h29) |=> o_cfg.overhead_voltage_code == $past(i_wdata[3:0]); endproperty
  a_ovh: assert property (p_ovh) else $error("overhead code not loaded");
  property p_dead; s_rd_dead |=> o_rdata == 16'h0000; endproperty
  a_dead: assert property (p_dead) else $error("dead address read nonzero");
  property p_ring; !i_ringing_active |=> !o_status.ring_tripped; endproperty
  a_ring: assert property (p_ring) else $error("ring trip outside ringing");
  property p_pos; $signed(i_meas.cm_voltage_pos) > pos_lvl |=> o_status.dc_speedup; endproperty
  a_pos: assert property (p_pos) else $error("speed-up missed");
endmodule // line_regs_chk
bind line_interface_control_regs line_regs_chk chk (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .i_meas, .i_ringing_active, .o_cfg, .o_status);

// [dv/line_interface_control_regs_tb_top.sv]
// bench for the supervision register bank
// assumes the package, header and bank are compiled first
`timescale 1ns/1ps
module line_interface_control_regs_tb_top;
  import line_ctrl_pkg::*;
  logic         i_clk, i_reset, i_wr, i_rd, i_hyst_enable, i_ringing_active, i_overhead_range_select;
  logic [7:0]   i_addr;
  logic [15:0]  i_wdata, o_rdata;
  line_meas_t   i_meas;
  line_cfg_t    o_cfg;
  line_status_t o_status;
  int           n_mismatch, checked;
  line_interface_control_regs dut (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_meas,
    .i_hyst_enable, .i_ringing_active, .i_overhead_range_select, .o_cfg, .o_status);
  // clock and watchdog
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  initial begin
    #100000;
    n_mismatch++;
    close_out;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // field mask per word, so that software leaves unused bits at zero
  function automatic logic [15:0] fmask(input int k);
    if (k < 4 || k == 15) return 16'h003f;
    else if (k < 7) return 16'h00ff;
    else if (k < 12) return 16'h1fff;
    else if (k < 14) return 16'h000f;
    else return 16'h0000;
  endfunction
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(o_rdata, e);
  endtask
  // status one edge after the inputs moved
  task st(input logic [5:0] e);
    @(posedge i_clk);
    @(negedge i_clk);
    chk({10'h0, o_status}, {10'h0, e});
  endtask
  task close_out;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial begin
    {i_reset, i_wr, i_rd, i_hyst_enable, i_ringing_active, i_overhead_range_select} = 6'h20;
    {i_addr, i_wdata} = '0;
    i_meas = '0;
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    @(negedge i_clk) chk({10'h0, o_status}, 16'h0000);
    for (int k = 0; k < 16; k++) wr(8'(8'h1c + k), 16'(16'hc3a0 + k) & fmask(k));
    for (int k = 0; k < 16; k++) rd(8'(8'h1c + k), 16'(16'hc3a0 + k) & fmask(k));
    chk({3'h0, o_cfg.ring_trip_filter_value}, 16'h03a8);
    chk({3'h0, o_cfg.thermal_pole_a}, 16'h03a9);
    chk({8'h0, o_cfg.power_alarm_level_b}, 16'h00a5);
    chk({12'h0, o_cfg.overhead_voltage_code}, 16'h000d);
    wr(8'h1b, 16'h1234);
    rd(8'h1b, 16'h0);
    rd(8'h2c, 16'h0);
    $display("test bank done");
    wr(8'h28, 16'h0);
    @(negedge i_clk) chk({12'h0, o_cfg.ringing_cm_bias}, 16'h0000);
    wr(8'h29, 16'h6);
    rd(8'h29, 16'h0006);
    @(posedge i_clk) i_overhead_range_select <= 1'b1;
    wr(8'h29, 16'h9);
    rd(8'h29, 16'h0009);
    chk({12'h0, o_cfg.overhead_voltage_code}, 16'h0009);
    wr(8'h1c, 16'h10);
    wr(8'h2b, 16'h08);
    wr(8'h1d, 16'h05);
    for (int k = 0; k < 5; k++) wr(8'(8'h1e + k), 16'h0010 >> (k < 2 ? 2 : 0));
    @(posedge i_clk);
    i_hyst_enable <= 1'b1;
    i_meas.loop_current <= 16'sd20;
    st(6'h20);
    @(posedge i_clk) i_meas.loop_current <= 16'sd12;
    st(6'h20);
    @(posedge i_clk) i_meas.loop_current <= 16'sd7;
    st(6'h00);
    @(posedge i_clk);
    i_hyst_enable <= 1'b0;
    i_meas.loop_current <= 16'sd17;
    st(6'h20);
    @(posedge i_clk) i_meas.loop_current <= 16'sd12;
    st(6'h00);
    wr(8'h1c, 16'h003e);
    @(posedge i_clk) i_meas.loop_current <= -16'sd1;
    st(6'h20);
    $display("test loop done");
    @(posedge i_clk) i_meas.ring_trip_sense <= 16'sd6;
    st(6'h20);
    @(posedge i_clk) i_ringing_active <= 1'b1;
    st(6'h30);
    @(posedge i_clk) i_meas.cm_voltage_neg <= 16'sd5;
    st(6'h38);
    @(posedge i_clk);
    i_meas.cm_voltage_neg <= 16'sd0;
    i_meas.cm_voltage_pos <= 16'sd4;
    st(6'h30);
    @(posedge i_clk) i_meas.cm_voltage_pos <= 16'sd5;
    st(6'h38);
    @(posedge i_clk) {i_meas.power_est_a, i_meas.power_est_b, i_meas.power_est_c} <= {3{16'sd17}};
    st(6'h3f);
    @(posedge i_clk) {i_meas.power_est_a, i_meas.power_est_b, i_meas.power_est_c} <= {3{16'sd16}};
    st(6'h38);
    $display("test supervision done");
    close_out;
  end
endmodule // line_interface_control_regs_tb_top
